// [verilog/irq_ctrl_pkg.sv]
// Constants, offsets and types shared by the interrupt controller files.
package irq_ctrl_pkg;

    // Number of external interrupt lines handled by the controller.
    localparam int NUM_LINES = 32;
    // Width of one priority field and the number of fields per priority word.
    localparam int PRIO_BITS      = 8;
    localparam int PRIO_PER_WORD  = 4;
    // Number of priority words and the width of their word index.
    localparam int PRIO_WORDS     = 8;
    localparam int PRIO_IDX_W     = 3;
    // Register byte addresses in the system control space.
    localparam logic [31:0] ENABLE_SET_ADDR    = 32'hE000E100;
    localparam logic [31:0] ENABLE_CLEAR_ADDR  = 32'hE000E180;
    localparam logic [31:0] PENDING_SET_ADDR   = 32'hE000E200;
    localparam logic [31:0] PENDING_CLEAR_ADDR = 32'hE000E280;
    localparam logic [31:0] PRIO_BASE_ADDR     = 32'hE000E400;
    localparam logic [31:0] PRIO_LAST_ADDR     = 32'hE000E41C;
    // Field positions of the word index inside a priority address.
    localparam int PRIO_IDX_LSB = 2;
    localparam int PRIO_IDX_MSB = 4;
    // Reset values of every register in the map.
    localparam logic [31:0] ENABLE_RESET   = 32'h00000000;
    localparam logic [31:0] PENDING_RESET  = 32'h00000000;
    localparam logic [31:0] PRIO_RESET     = 32'h00000000;
    localparam logic [31:0] READ_NONE_DATA = 32'h00000000;
    // Clock edges from a taken read to its data on the read port.
    localparam int READ_LATENCY = 2;

    // Which register a read in flight is returning.
    typedef enum logic [2:0] {
        SEL_NONE    = 3'b000,
        SEL_ENABLE  = 3'b001,
        SEL_PENDING = 3'b010,
        SEL_PRIO    = 3'b011
    } read_sel_t;

endpackage : irq_ctrl_pkg

// [verilog/prio_mem.sv]
// Small register memory that holds the packed interrupt priority words.
`timescale 1ns/1ps
module prio_mem #(
    parameter int WIDTH  = 32,
    parameter int DEPTH  = 8,
    parameter int ADDR_W = 3
) (
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    input  wire logic              wr_en_in,
    input  wire logic [ADDR_W-1:0] wr_addr_in,
    input  wire logic [WIDTH-1:0]  wr_data_in,
    input  wire logic              rd_en_in,
    input  wire logic [ADDR_W-1:0] rd_addr_in,
    output logic      [WIDTH-1:0]  rd_data_out
);

    // The storage words; reset clears every priority to zero.
    logic [WIDTH-1:0] mem_reg [DEPTH];
    // Registered read data, so the word leaves this module from a flip-flop.
    logic [WIDTH-1:0] rd_data_reg;

    // Write port: whole words only, the caller masks fields that do not exist.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_reg[i] <= WIDTH'(irq_ctrl_pkg::PRIO_RESET);
            end
        end
        else if (wr_en_in)
        begin
            mem_reg[wr_addr_in] <= wr_data_in;
        end
    end

    // Read port: data appears one edge after the request.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rd_data_reg <= '0;
        end
        else if (rd_en_in)
        begin
            rd_data_reg <= mem_reg[rd_addr_in];
        end
    end

    assign rd_data_out = rd_data_reg;

endmodule : prio_mem

// [verilog/nested_interrupt_controller.sv]
// Interrupt controller: per-line enable, pending and active state with its registers.
// Contract
// - Thirty-two lines, each with enable, pending, priority.
// - New pulse while active sets pending again.
// - Many pulses while active give one event.
// - Level still high at return re-pends line.
// - Write-one enables or disables; both read enables.
// - Disabled asserted line still becomes pending.
// - Disabling keeps active; blocks any new activation.
// - Missing lines tie enable low; fixed lines high.
// - Write-one sets or clears pending; both read pending.
// - Clearing pending never touches active state.
// - Software set and clear pending chosen per line.
// - Eight-bit priorities, four to each word.
// - Inputs active high, level or pulse per line.
// - Edge is low then high on clock edges.
// - Assert on edge, or high at resample strobes.
// - Deassert only on clear-pending write while low.
// - Entry or deassert clears; assert or write sets.
// - Same-cycle set and clear: set wins here.
// - Bit n of enable and pending registers is line n.
`timescale 1ns/1ps
module nested_interrupt_controller #(
    parameter logic [31:0] IMPL_MASK   = 32'hFFFFFFFF,
    parameter logic [31:0] FIXED_EN    = 32'h00000000,
    parameter logic [31:0] SW_SET_MASK = 32'hFFFFFFFF,
    parameter logic [31:0] SW_CLR_MASK = 32'hFFFFFFFF
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [31:0] irq_in,
    input  wire logic [31:0] exc_entry_strobe_in,
    input  wire logic [31:0] exc_return_strobe_in,
    input  wire logic        clear_active_vector_strobe_in,
    input  wire logic [31:0] reg_addr_in,
    input  wire logic        reg_wr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    output logic             reg_rvalid_out,
    output logic      [31:0] irq_request_out,
    output logic      [31:0] active_out,
    output logic      [31:0] enable_out,
    output logic      [31:0] pending_out
);

    // Keeps the priority bytes of lines that do not exist reading as zero.
    function automatic logic [31:0] prio_word_mask(input logic [2:0] idx);
        logic [31:0] m;
        m = '0;
        for (int f = 0; f < irq_ctrl_pkg::PRIO_PER_WORD; f++)
        begin
            if (IMPL_MASK[32'(idx) * irq_ctrl_pkg::PRIO_PER_WORD + f])
            begin
                m[f*irq_ctrl_pkg::PRIO_BITS +: irq_ctrl_pkg::PRIO_BITS] = 8'hFF;
            end
        end
        return m;
    endfunction : prio_word_mask

    // Two-stage synchroniser and history flop for the peripheral lines.
    logic [31:0] irq_meta_reg;   // First stage, read only by the second.
    logic [31:0] irq_sync_reg;   // Safe sampled level of each line.
    logic [31:0] irq_prev_reg;   // Level one edge earlier, for edge detection.
    // Controller state, one bit per line.
    // thirty-two lines kept
    logic [31:0] enable_reg;
    logic [31:0] pending_reg;
    logic [31:0] active_reg;
    logic [31:0] irq_request_reg;
    // Read pipeline state.
    irq_ctrl_pkg::read_sel_t rd_sel_reg;
    logic                    rd_valid_reg;
    logic [31:0]             rdata_reg;
    logic                    rvalid_reg;
    logic [2:0]              rd_idx_reg;
    // Combinational decode and per-line events.
    logic        wr_en_set, wr_en_clr, wr_pend_set, wr_pend_clr, wr_prio, rd_prio;
    logic [2:0]  prio_idx;
    logic [31:0] prio_rdata;
    logic [31:0] rise_w, resample_high_cond, resample_low_cond;
    logic [31:0] assert_event, deassert_event;
    logic [31:0] pend_set_cond, pend_clear_cond, entry_ok;
    logic [31:0] enable_next, pending_next, active_next;

    // Address decode of the five register groups; other addresses are ignored.
    always_comb
    begin
        wr_en_set   = reg_wr_in && (reg_addr_in == irq_ctrl_pkg::ENABLE_SET_ADDR);
        wr_en_clr   = reg_wr_in && (reg_addr_in == irq_ctrl_pkg::ENABLE_CLEAR_ADDR);
        wr_pend_set = reg_wr_in && (reg_addr_in == irq_ctrl_pkg::PENDING_SET_ADDR);
        wr_pend_clr = reg_wr_in && (reg_addr_in == irq_ctrl_pkg::PENDING_CLEAR_ADDR);
        rd_prio     = (reg_addr_in >= irq_ctrl_pkg::PRIO_BASE_ADDR)
                   && (reg_addr_in <= irq_ctrl_pkg::PRIO_LAST_ADDR)
                   && (reg_addr_in[1:0] == 2'h0);
        wr_prio     = reg_wr_in && rd_prio;
        prio_idx    = reg_addr_in[irq_ctrl_pkg::PRIO_IDX_MSB:irq_ctrl_pkg::PRIO_IDX_LSB];
    end

    // Peripheral lines come from outside this logic, so they are synchronised.
    // active-high lines sampled
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            irq_meta_reg <= '0;
            irq_sync_reg <= '0;
            irq_prev_reg <= '0;
        end
        else
        begin
            irq_meta_reg <= irq_in;
            irq_sync_reg <= irq_meta_reg;
            irq_prev_reg <= irq_sync_reg;
        end
    end

    // Per-line events. Level and pulse lines share one equation: a pulse that
    // is dropped before the resample strobes simply never looks like a level.
    always_comb
    begin
        rise_w             = irq_sync_reg & ~irq_prev_reg;
        resample_high_cond = {32{clear_active_vector_strobe_in}} | exc_return_strobe_in;
        resample_low_cond  = {32{wr_pend_clr}} & reg_wdata_in & SW_CLR_MASK;
        assert_event       = rise_w | (irq_sync_reg & resample_high_cond);
        deassert_event     = ~irq_sync_reg & resample_low_cond;
        entry_ok           = exc_entry_strobe_in & enable_reg & pending_reg;
        pend_clear_cond    = entry_ok | deassert_event;
        pend_set_cond      = assert_event | ({32{wr_pend_set}} & reg_wdata_in & SW_SET_MASK);
        pending_next       = (pend_set_cond | (pending_reg & ~pend_clear_cond)) & IMPL_MASK;
        enable_next        = (((enable_reg | ({32{wr_en_set}} & reg_wdata_in))
                             & ~({32{wr_en_clr}} & reg_wdata_in)) | FIXED_EN) & IMPL_MASK;
        active_next        = (active_reg | entry_ok)
                           & ~exc_return_strobe_in & ~{32{clear_active_vector_strobe_in}};
    end

    // Enable state; writing zero bits leaves lines untouched.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            enable_reg <= irq_ctrl_pkg::ENABLE_RESET | (FIXED_EN & IMPL_MASK);
        end
        else
        begin
            enable_reg <= enable_next;
        end
    end

    // Pending state is evaluated once per clock from the events above.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pending_reg <= irq_ctrl_pkg::PENDING_RESET;
        end
        else
        begin
            pending_reg <= pending_next;
        end
    end

    // Active state and the request presented to the core's arbitration.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            active_reg      <= '0;
            irq_request_reg <= '0;
        end
        else
        begin
            active_reg      <= active_next;
            irq_request_reg <= pending_next & enable_next;
        end
    end

    // Priority words live in their own memory; absent fields never store.
    prio_mem #(
        .WIDTH  (32),
        .DEPTH  (irq_ctrl_pkg::PRIO_WORDS),
        .ADDR_W (irq_ctrl_pkg::PRIO_IDX_W)
    ) u_prio_mem (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .wr_en_in    (wr_prio),
        .wr_addr_in  (prio_idx),
        .wr_data_in  (reg_wdata_in & prio_word_mask(prio_idx)),
        .rd_en_in    (reg_rd_in && rd_prio),
        .rd_addr_in  (prio_idx),
        .rd_data_out (prio_rdata)
    );

    // First read stage: remember what was asked while memory is read.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rd_sel_reg   <= irq_ctrl_pkg::SEL_NONE;
            rd_valid_reg <= 1'b0;
            rd_idx_reg   <= '0;
        end
        else
        begin
            rd_valid_reg <= reg_rd_in;
            rd_idx_reg   <= prio_idx;
            if (!reg_rd_in)
            begin
                rd_sel_reg <= irq_ctrl_pkg::SEL_NONE;
            end
            else if (reg_addr_in == irq_ctrl_pkg::ENABLE_SET_ADDR
                  || reg_addr_in == irq_ctrl_pkg::ENABLE_CLEAR_ADDR)
            begin
                rd_sel_reg <= irq_ctrl_pkg::SEL_ENABLE;
            end
            else if (reg_addr_in == irq_ctrl_pkg::PENDING_SET_ADDR
                  || reg_addr_in == irq_ctrl_pkg::PENDING_CLEAR_ADDR)
            begin
                rd_sel_reg <= irq_ctrl_pkg::SEL_PENDING;
            end
            else if (rd_prio)
            begin
                rd_sel_reg <= irq_ctrl_pkg::SEL_PRIO;
            end
            else
            begin
                // Unmapped and reserved addresses read as zero.
                rd_sel_reg <= irq_ctrl_pkg::SEL_NONE;
            end
        end
    end

    // Second read stage: the answer, two edges after the request.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rdata_reg  <= irq_ctrl_pkg::READ_NONE_DATA;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            rvalid_reg <= rd_valid_reg;
            case (rd_sel_reg)
                irq_ctrl_pkg::SEL_ENABLE:  rdata_reg <= enable_reg;
                irq_ctrl_pkg::SEL_PENDING: rdata_reg <= pending_reg;
                irq_ctrl_pkg::SEL_PRIO:    rdata_reg <= prio_rdata & prio_word_mask(rd_idx_reg);
                irq_ctrl_pkg::SEL_NONE:    rdata_reg <= irq_ctrl_pkg::READ_NONE_DATA;
                default:                   rdata_reg <= irq_ctrl_pkg::READ_NONE_DATA;
            endcase
        end
    end

    // All outputs leave straight from flip-flops.
    assign reg_rdata_out   = rdata_reg;
    assign reg_rvalid_out  = rvalid_reg;
    assign irq_request_out = irq_request_reg;
    assign active_out      = active_reg;
    assign enable_out      = enable_reg;
    assign pending_out     = pending_reg;

    // Checks on the controller's own behaviour.
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // A detected edge leaves the line pending at the next edge.
    edge_pends_a: assert property (
        1'b1 |=> ((pending_reg & $past(rise_w & IMPL_MASK)) == $past(rise_w & IMPL_MASK)))
        else $error("edge did not set pending");

    // Any set beats a same-cycle clear.
    set_wins_a: assert property (
        1'b1 |=> ((pending_reg & $past(pend_set_cond & IMPL_MASK))
                  == $past(pend_set_cond & IMPL_MASK)))
        else $error("set lost against clear");

    // A disabled line is never requested.
    no_req_disabled_a: assert property (
        (irq_request_out & ~enable_reg) == 32'h00000000)
        else $error("request on disabled line");

    // Write-one-to-set enable takes effect at the next edge.
    enable_set_a: assert property (
        wr_en_set |=> ((enable_reg & $past(reg_wdata_in & IMPL_MASK))
                       == $past(reg_wdata_in & IMPL_MASK)))
        else $error("enable set write lost");

    // A deassertion without a competing set clears the bit.
    deassert_clears_a: assert property (
        1'b1 |=> ((pending_reg & $past(deassert_event & ~pend_set_cond)) == 32'h00000000))
        else $error("deassertion did not clear pending");

    // Clear-pending writes leave active state alone.
    active_kept_a: assert property (
        wr_pend_clr && !clear_active_vector_strobe_in && exc_return_strobe_in == 32'h00000000
        && exc_entry_strobe_in == 32'h00000000 |=> active_reg == $past(active_reg))
        else $error("active changed by clear pending");

    // A level still high at return pends again.
    level_repend_a: assert property (
        1'b1 |=> ((pending_reg & $past(irq_sync_reg & exc_return_strobe_in & IMPL_MASK))
                  == $past(irq_sync_reg & exc_return_strobe_in & IMPL_MASK)))
        else $error("level line not re-pended");

    // An active line that sees an edge becomes active and pending.
    active_pending_a: assert property (
        (active_reg & rise_w & IMPL_MASK) != 32'h00000000 && exc_return_strobe_in == 32'h00000000
        && !clear_active_vector_strobe_in
        |=> (active_reg & pending_reg & $past(active_reg & rise_w & IMPL_MASK))
            == $past(active_reg & rise_w & IMPL_MASK))
        else $error("active line not made pending");

    // Enable reads return the enable state two edges later.
    enable_read_a: assert property (
        reg_rd_in && reg_addr_in == irq_ctrl_pkg::ENABLE_CLEAR_ADDR
        |-> ##2 (reg_rvalid_out && reg_rdata_out == $past(enable_reg)))
        else $error("enable readback wrong");

endmodule : nested_interrupt_controller

// [tb/core_irq_model.sv]
// Behavioural model of the core exception strobes and the peripheral interrupt lines.
`timescale 1ns/1ps
module core_irq_model (
    input  wire logic        clk_in,
    output logic      [31:0] irq_out,
    output logic      [31:0] entry_out,
    output logic      [31:0] return_out,
    output logic             cav_out
);
    // Every line idle and every strobe low from time zero.
    initial
    begin
        irq_out    = 32'h00000000;
        entry_out  = 32'h00000000;
        return_out = 32'h00000000;
        cav_out    = 1'b0;
    end

    // pulse held, then dropped
    // The pulse spans two clocks so the synchroniser cannot miss it, and it is gone
    // before any later return, so the line is never mistaken for a level.
    task pulse(input int n);
        @(posedge clk_in);
        #1 irq_out[n] = 1'b1;
        repeat (2) @(posedge clk_in);
        #1 irq_out[n] = 1'b0;
    endtask : pulse

    // A level source stays where it is put until told otherwise.
    task level(input int n, input logic v);
        @(posedge clk_in);
        #1 irq_out[n] = v;
    endtask : level

    // one-cycle core strobes
    // Kind 0 is entry, 1 is return, anything else the clear-active-vector write.
    task strobe(input int kind, input int n);
        @(posedge clk_in);
        #1;
        case (kind)
            0: entry_out[n] = 1'b1;
            1: return_out[n] = 1'b1;
            default: cav_out = 1'b1;
        endcase
        @(posedge clk_in);
        #1;
        entry_out  = 32'h00000000;
        return_out = 32'h00000000;
        cav_out    = 1'b0;
    endtask : strobe
endmodule : core_irq_model

// [tb/test_nested_interrupt_controller.sv]
// Self-checking bench for the interrupt controller, driven through its register port.
`timescale 1ns/1ps
module test_nested_interrupt_controller;
    // Line 31 absent, line 15 always on, line 7 no software set, line 6 no software clear.
    localparam logic [31:0] IMPL  = 32'h7FFFFFFF;
    localparam logic [31:0] FIXED = 32'h00008000;
    localparam logic [31:0] SSET  = 32'hFFFFFF7F;
    localparam logic [31:0] SCLR  = 32'hFFFFFFBF;
    logic        clk_in      = 1'b0;
    logic        rst_in      = 1'b1;
    logic [31:0] reg_addr_in = 32'h00000000;
    logic        reg_wr_in   = 1'b0;
    logic [31:0] reg_wdata_in = 32'h00000000;
    logic        reg_rd_in   = 1'b0;
    logic [31:0] irq, ent, ret, rdata, req, act, en, pend;
    logic        cav, rvalid;
    int          num_errors  = 0;
    int          comparisons = 0;

    // Free-running 250 MHz clock.
    always #2 clk_in = ~clk_in;

    nested_interrupt_controller #(.IMPL_MASK(IMPL), .FIXED_EN(FIXED),
        .SW_SET_MASK(SSET), .SW_CLR_MASK(SCLR)) uut (
        .clk_in(clk_in), .rst_in(rst_in), .irq_in(irq), .exc_entry_strobe_in(ent),
        .exc_return_strobe_in(ret), .clear_active_vector_strobe_in(cav),
        .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .irq_request_out(req), .active_out(act), .enable_out(en), .pending_out(pend));

    core_irq_model core (.clk_in(clk_in), .irq_out(irq), .entry_out(ent),
        .return_out(ret), .cav_out(cav));

    // Verdict and end of run; the only place the run finishes.
    task test_done;
        if (num_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    // Word comparison, counted and reported.
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Single-bit comparison for per-line state.
    task chkb(input string nm, input logic e, input logic g);
        comparisons++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask : chkb

    // Let n clocks pass, then settle just after the edge.
    task tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick

    // One-cycle write strobe; the effect is visible once the taking edge has passed.
    task wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_in);
        #1 reg_wr_in = 1'b1;
        reg_addr_in  = a;
        reg_wdata_in = d;
        @(posedge clk_in);
        #1 reg_wr_in = 1'b0;
    endtask : wr

    // One-cycle read strobe, then a bounded wait for the one-cycle valid pulse.
    task rd(input logic [31:0] a, input logic [31:0] e, input string nm);
        int i;
        @(posedge clk_in);
        #1 reg_rd_in = 1'b1;
        reg_addr_in = a;
        @(posedge clk_in);
        #1 reg_rd_in = 1'b0;
        i = 0;
        while (rvalid !== 1'b1 && i < 4)
        begin
            tick(1);
            i++;
        end
        if (i == 4)
        begin
            $display("[ERR] reg_rvalid_out expected 1 seen 0");
            num_errors++;
            test_done();
        end
        chk(nm, e, rdata);
    endtask : rd

    // Main sequence; the reserved address probes check that holes read as zero and ignore writes.
    initial
    begin
        repeat (6) @(posedge clk_in);
        #1 rst_in = 1'b0;
        chk("enable_out", FIXED & IMPL, en);
        chk("pending_out", 32'h00000000, pend);
        rd(irq_ctrl_pkg::ENABLE_SET_ADDR, FIXED, "enable_set");
        rd(irq_ctrl_pkg::PENDING_SET_ADDR, 32'h00000000, "pending_set");
        rd(32'hE000E104, 32'h00000000, "reserved");
        wr(irq_ctrl_pkg::ENABLE_SET_ADDR, 32'hFFFFFFFF);
        chk("enable_out", IMPL, en);
        wr(irq_ctrl_pkg::ENABLE_CLEAR_ADDR, 32'h0000800F);
        chk("enable_out", 32'h7FFFFFF0, en);
        wr(irq_ctrl_pkg::ENABLE_SET_ADDR, 32'h00000000);
        rd(irq_ctrl_pkg::ENABLE_CLEAR_ADDR, 32'h7FFFFFF0, "enable_clear");
        wr(irq_ctrl_pkg::ENABLE_SET_ADDR, 32'h0000000F);
        chk("enable_out", IMPL, en);
        // Priority words: full word round trip, absent byte, unmapped neighbour.
        wr(irq_ctrl_pkg::PRIO_BASE_ADDR + 32'h4, 32'hA1B2C3D4);
        rd(irq_ctrl_pkg::PRIO_BASE_ADDR + 32'h4, 32'hA1B2C3D4, "prio_word1");
        wr(irq_ctrl_pkg::PRIO_LAST_ADDR, 32'hFFFFFFFF);
        rd(irq_ctrl_pkg::PRIO_LAST_ADDR, 32'h00FFFFFF, "prio_word7");
        wr(32'hE000E420, 32'hFFFFFFFF);
        rd(irq_ctrl_pkg::PRIO_BASE_ADDR, 32'h00000000, "prio_word0");
        // Software pending with per-line capability masks.
        wr(irq_ctrl_pkg::PENDING_SET_ADDR, 32'h000000C1);
        chk("pending_out", 32'h00000041, pend);
        chk("irq_request_out", 32'h00000041, req);
        rd(irq_ctrl_pkg::PENDING_CLEAR_ADDR, 32'h00000041, "pending_clear");
        wr(irq_ctrl_pkg::PENDING_CLEAR_ADDR, 32'h000000FF);
        chk("pending_out", 32'h00000040, pend);
        // Pulse line 3: edge, entry, re-pend while active, clear, return.
        core.pulse(3);
        tick(4);
        chkb("pending3", 1'b1, pend[3]);
        core.strobe(0, 3);
        chkb("active3", 1'b1, act[3]);
        chkb("pending3", 1'b0, pend[3]);
        core.pulse(3);
        core.pulse(3);
        tick(4);
        chkb("pending3", 1'b1, pend[3]);
        wr(irq_ctrl_pkg::PENDING_CLEAR_ADDR, 32'h00000008);
        chkb("pending3", 1'b0, pend[3]);
        chkb("active3", 1'b1, act[3]);
        core.strobe(1, 3);
        chkb("active3", 1'b0, act[3]);
        chkb("pending3", 1'b0, pend[3]);
        // Level line 4 still high at return.
        core.level(4, 1'b1);
        tick(4);
        core.strobe(0, 4);
        chkb("pending4", 1'b0, pend[4]);
        core.strobe(1, 4);
        chkb("pending4", 1'b1, pend[4]);
        wr(irq_ctrl_pkg::PENDING_CLEAR_ADDR, 32'h00000010);
        chkb("pending4", 1'b1, pend[4]);
        core.level(4, 1'b0);
        tick(4);
        wr(irq_ctrl_pkg::PENDING_CLEAR_ADDR, 32'h00000010);
        chkb("pending4", 1'b0, pend[4]);
        // Disabled line 5 pends but never activates.
        wr(irq_ctrl_pkg::ENABLE_CLEAR_ADDR, 32'h00000020);
        core.pulse(5);
        tick(4);
        chkb("pending5", 1'b1, pend[5]);
        chkb("request5", 1'b0, req[5]);
        core.strobe(0, 5);
        chkb("active5", 1'b0, act[5]);
        // Line 8 disabled while active stays active until return.
        core.pulse(8);
        tick(4);
        core.strobe(0, 8);
        wr(irq_ctrl_pkg::ENABLE_CLEAR_ADDR, 32'h00000100);
        chkb("active8", 1'b1, act[8]);
        core.strobe(1, 8);
        chkb("active8", 1'b0, act[8]);
        // Clear-active-vector write resamples a high line 9.
        core.level(9, 1'b1);
        tick(4);
        core.strobe(0, 9);
        chkb("pending9", 1'b0, pend[9]);
        core.strobe(2, 0);
        chkb("active9", 1'b0, act[9]);
        chkb("pending9", 1'b1, pend[9]);
        // Entry and software set on line 10 in the same cycle: set wins.
        wr(irq_ctrl_pkg::PENDING_SET_ADDR, 32'h00000400);
        fork
            wr(irq_ctrl_pkg::PENDING_SET_ADDR, 32'h00000400);
            core.strobe(0, 10);
        join
        chkb("active10", 1'b1, act[10]);
        chkb("pending10", 1'b1, pend[10]);
        test_done();
    end
endmodule : test_nested_interrupt_controller
